// ==== bench/jtxl_link_ctrl_tb.sv ====
// Self-checking bench for the transmit link control block
`timescale 1ns/100ps
`include "jtxl_params.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_errors++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module jtxl_link_ctrl_tb;
  import jtxl_pkg::*;
  logic clk = 0;
  logic srst = 1;
  logic cyc = 0;
  logic stb = 0;
  logic we = 0;
  logic req = 1;
  logic [13:0] adr = '0;
  logic [3:0] sel = '0;
  logic [31:0] dat_i = '0;
  logic [31:0] dat_o;
  logic ack;
  logic sync_n;
  logic lmfc;
  logic [7:0] sample = 8'h6B;
  logic [7:0] scrambled = 8'h93;
  logic [9:0] enc = 10'h1C3;
  logic [87:0] cfg = {88{1'b1}};
  logic [7:0] scr_data;
  logic scr_k;
  logic [9:0] line;
  logic ilas;
  logic [7:0] csum;
  jtxl_state_t state;
  int n_errors = 0;
  int check_count = 0;
  always #5 clk = ~clk;
  jtxl_rx_model #(.LMFC_PERIOD(4)) rx (.clk_i(clk), .srst_i(srst), .req_i(req),
    .sync_n_o(sync_n), .lmfc_o(lmfc));
  jtxl_link_ctrl uut (.CLK_SYS_I(clk), .SRST_I(srst), .LINK_PD_I(1'b0), .CYC_I(cyc),
    .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(dat_i), .DAT_O(dat_o),
    .ACK_O(ack), .LINK_SYNC_REQUEST_PIN_N_I(sync_n), .LMFC_I(lmfc), .SAMPLE_I(sample),
    .CFG_TABLE_I(cfg), .SCR_DATA_O(scr_data), .SCR_K_O(scr_k), .SCRAMBLED_I(scrambled),
    .ENC_SYMBOL_I(enc), .LINE_SYMBOL_O(line), .ILAS_START_O(ilas), .CHECKSUM_O(csum),
    .LINK_STATE_O(state));
  task automatic conclude;
    $display("checks=%0d errors=%0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic wb(input logic w, input logic [11:0] idx, input logic [7:0] d,
      output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    dat_i <= {24'h0, d};
    sel <= 4'h1;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) n_errors++;
    q = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, idx, d, q);
  endtask
  task automatic rd_chk(input logic [11:0] idx, input logic [7:0] e);
    logic [7:0] q;
    wb(1'b0, idx, 8'h00, q);
    `CHK(q, e)
  endtask
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic t_regs;
    rd_chk(`JTXL_IDX_CTRL3, `JTXL_RST_CTRL3);
    rd_chk(`JTXL_IDX_CTRL4, `JTXL_RST_CTRL4);
    rd_chk(`JTXL_IDX_CODING, `JTXL_RST_CODING);
    wr(`JTXL_IDX_CTRL4, 8'hFF);
    rd_chk(`JTXL_IDX_CTRL4, 8'hF7);
    wr(`JTXL_IDX_CTRL3, 8'hA5);
    rd_chk(`JTXL_IDX_CTRL3, 8'hA5);
    wr(12'h7FF, 8'h5A);
    rd_chk(12'h7FF, 8'h00);
  endtask
  task automatic t_csum;
    logic [7:0] exp [4] = '{8'hF5, 8'h09, 8'h00, 8'h00};
    for (int m = 0; m < 4; m++) begin
      wr(`JTXL_IDX_CTRL3, {m[1:0], 6'h00});
      settle;
      `CHK(csum, exp[m])
      rd_chk(`JTXL_IDX_CSUM, exp[m]);
    end
  endtask
  task automatic t_sync(input logic [3:0] n);
    int pulses;
    int k;
    pulses = 0;
    k = 0;
    wr(`JTXL_IDX_CTRL4, {n, 4'h0});
    req <= 1'b1;
    repeat (8) @(posedge clk);
    #1 `CHK(state, JTXL_ST_CGS)
    `CHK({scr_k, scr_data}, {1'b1, `JTXL_K28_5})
    @(posedge clk);
    req <= 1'b0;
    while (state !== JTXL_ST_WAIT && k < 100) begin
      @(posedge clk);
      #1 k++;
    end
    // Count boundaries seen by the block while waiting
    while (ilas !== 1'b1 && k < 200) begin
      @(posedge clk);
      pulses += lmfc;
      #1 k++;
    end
    `CHK(pulses, int'(n) + 1)
    `CHK(state, JTXL_ST_DATA)
    @(posedge clk);
    #1 `CHK(ilas, 1'b0)
    rd_chk(`JTXL_IDX_STATUS, 8'h02);
  endtask
  task automatic t_path;
    wr(`JTXL_IDX_CTRL3, 8'h00);
    settle;
    `CHK(scr_data, sample)
    `CHK(line, enc)
    wr(`JTXL_IDX_CODING, 8'h04);
    settle;
    `CHK(line, {2'b00, scrambled})
    wr(`JTXL_IDX_CODING, 8'h06);
    settle;
    `CHK(line, ~{2'b00, scrambled})
    wr(`JTXL_IDX_CODING, 8'h00);
  endtask
  task automatic t_alt(input logic [7:0] c, input logic [9:0] a);
    logic [9:0] m;
    logic [9:0] w;
    m = (c[5:4] != 2'b01) ? 10'h0FF : 10'h3FF;
    wr(`JTXL_IDX_CTRL3, c);
    settle;
    w = (c[5:4] != 2'b01) ? {2'b00, scr_data} : line;
    `CHK(w == (a & m) || w == (~a & m), 1'b1)
    @(posedge clk);
    #1 `CHK((c[5:4] != 2'b01) ? {2'b00, scr_data} : line, w ^ m)
  endtask
  task automatic t_misc;
    logic [9:0] w;
    wr(`JTXL_IDX_CTRL3, 8'h18);
    settle;
    w = line;
    @(posedge clk);
    #1 `CHK(line, w + 10'h001)
    wr(`JTXL_IDX_USER, 8'h3C);
    wr(`JTXL_IDX_CTRL3, 8'h1E);
    settle;
    `CHK(line, 10'h03C)
    wr(`JTXL_IDX_CTRL3, 8'h1F);
    @(posedge clk);
    #1 `CHK(line, 10'h03C)
    @(posedge clk);
    #1 `CHK(line, enc)
    settle;
    `CHK(line, enc)
  endtask
  task automatic t_prbs(input logic [3:0] code, input int a, input int b);
    logic q [$];
    int bad;
    int ones;
    bad = 0;
    ones = 0;
    wr(`JTXL_IDX_CTRL3, {4'h1, code});
    settle;
    for (int i = 0; i < 8; i++) begin
      for (int j = 9; j >= 0; j--) q.push_back(line[j]);
      @(posedge clk);
      #1;
    end
    for (int n = a; n < q.size(); n++) begin
      bad += (q[n] !== (q[n - a] ^ q[n - b]));
      ones += q[n];
    end
    `CHK(bad, 0)
    `CHK(ones > 0, 1'b1)
  endtask
  task automatic t_force;
    wr(`JTXL_IDX_CODING, 8'h80);
    settle;
    `CHK(state, JTXL_ST_CGS)
    `CHK(scr_k, 1'b1)
    wr(`JTXL_IDX_CODING, 8'hC0);
    settle;
    `CHK(state, JTXL_ST_WAIT)
    wr(`JTXL_IDX_CODING, 8'h20);
    settle;
    `CHK(state, JTXL_ST_CGS)
    `CHK(scr_k, 1'b1)
    wr(`JTXL_IDX_CODING, 8'h00);
  endtask
  initial begin
    #200000;
    n_errors++;
    conclude;
  end
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    t_regs;
    t_csum;
    t_sync(4'h0);
    t_sync(4'hF);
    t_path;
    t_alt(8'h01, `JTXL_CHECKER_A);
    t_alt(8'h11, `JTXL_CHECKER_A);
    t_alt(8'h12, 10'h000);
    t_alt(8'h21, `JTXL_CHECKER_A);
    t_misc;
    t_prbs(4'h3, 31, 28);
    t_prbs(4'h4, 23, 18);
    t_prbs(4'h5, 15, 14);
    t_prbs(4'h6, 9, 5);
    t_prbs(4'h7, 7, 6);
    t_force;
    conclude;
  end
endmodule

// ==== bench/jtxl_rx_model.sv ====
// Receiver side model: sync request line and multiframe boundary pulses
`timescale 1ns/100ps
module jtxl_rx_model #(parameter int LMFC_PERIOD = 4) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic req_i,
  output logic sync_n_o,
  output logic lmfc_o
);
  int cnt;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt <= 0;
      sync_n_o <= 1'b0;
    end else begin
      cnt <= (cnt == LMFC_PERIOD - 1) ? 0 : cnt + 1;
      // Change only mid-multiframe, away from a boundary
      if (cnt == 1) begin
        sync_n_o <= ~req_i;
      end
    end
  end
  assign lmfc_o = !srst_i && cnt == 0;
endmodule

// ==== logic/jtxl_link_ctrl.sv ====
// Transmit link test pattern, coding, checksum and alignment start control
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/100ps
`include "jtxl_params.svh"
module jtxl_link_ctrl (
  input wire logic CLK_SYS_I,
  input wire logic SRST_I,
  input wire logic LINK_PD_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [13:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  input wire logic LINK_SYNC_REQUEST_PIN_N_I,
  input wire logic LMFC_I,
  input wire logic [7:0] SAMPLE_I,
  input wire logic [87:0] CFG_TABLE_I,
  output logic [7:0] SCR_DATA_O,
  output logic SCR_K_O,
  input wire logic [7:0] SCRAMBLED_I,
  input wire logic [9:0] ENC_SYMBOL_I,
  output logic [9:0] LINE_SYMBOL_O,
  output logic ILAS_START_O,
  output logic [7:0] CHECKSUM_O,
  output jtxl_pkg::jtxl_state_t LINK_STATE_O
);
  import jtxl_pkg::*;

  function automatic logic [7:0] byte_sum(input logic [87:0] t);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 11; i++) begin
      s = s + t[8*i +: 8];
    end
    return s;
  endfunction

  function automatic logic [7:0] field_sum(input logic [87:0] t);
    logic [7:0] s;
    s = t[7:0];
    s = s + {4'h0, t[11:8]} + {4'h0, t[15:12]};
    s = s + {3'h0, t[20:16]} + {7'h00, t[21]} + {7'h00, t[22]};
    s = s + {3'h0, t[28:24]} + {7'h00, t[31]};
    s = s + t[39:32] + {3'h0, t[44:40]} + t[55:48];
    s = s + {3'h0, t[60:56]} + {6'h00, t[63:62]};
    s = s + {3'h0, t[68:64]} + {5'h00, t[71:69]};
    s = s + {3'h0, t[76:72]} + {5'h00, t[79:77]};
    s = s + {3'h0, t[84:80]} + {7'h00, t[87]};
    return s;
  endfunction

  function automatic logic [40:0] prbs_step(input logic [30:0] st_in, input logic [3:0] m);
    logic [30:0] st;
    logic [9:0] o;
    logic fb;
    st = st_in;
    o = 10'h000;
    for (int k = 0; k < 10; k++) begin
      case (m)
        JTXL_TP_PN31: fb = st[30] ^ st[27];
        JTXL_TP_PN23: fb = st[22] ^ st[17];
        JTXL_TP_PN15: fb = st[14] ^ st[13];
        JTXL_TP_PN9: fb = st[8] ^ st[4];
        default: fb = st[6] ^ st[5];
      endcase
      st = {st[29:0], fb};
      o = {o[8:0], fb};
    end
    return {o, st};
  endfunction

  logic [7:0] coding_reg;
  logic [7:0] ctrl3_reg;
  logic [7:0] ctrl4_reg;
  logic [7:0] user_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [7:0] csum_reg;
  jtxl_state_t state_reg;
  jtxl_state_t state_next;
  logic [3:0] lmfc_cnt_reg;
  logic ilas_reg;
  logic [30:0] prbs_reg;
  logic [3:0] tpat_q_reg;
  logic phase_reg;
  logic [9:0] ramp_reg;
  logic user_done_reg;
  logic [7:0] scr_data_reg;
  logic scr_k_reg;
  logic [9:0] line_reg;

  // Bus decode
  wire link_rst = SRST_I | LINK_PD_I;
  wire wb_req = CYC_I & STB_I;
  wire [11:0] idx = ADR_I[13:2];
  wire wr_en = wb_req & WE_I & ack_reg & SEL_I[0];
  wire hit_coding = idx == `JTXL_IDX_CODING;
  wire hit_ctrl3 = idx == `JTXL_IDX_CTRL3;
  wire hit_ctrl4 = idx == `JTXL_IDX_CTRL4;
  wire hit_user = idx == `JTXL_IDX_USER;
  wire [7:0] wbyte = DAT_I[7:0];

  // Control fields
  wire [1:0] sync_ctrl = coding_reg[`JTXL_SYNC_CTRL];
  wire bypass = coding_reg[`JTXL_BYPASS];
  wire invert = coding_reg[`JTXL_INVERT];
  wire [1:0] csum_mode = ctrl3_reg[`JTXL_CSUM_MODE];
  wire [1:0] inj = ctrl3_reg[`JTXL_INJ_POINT];
  wire [3:0] tpat = ctrl3_reg[`JTXL_TEST_PAT];
  wire [3:0] ilas_dly = ctrl4_reg[`JTXL_ILAS_DLY];

  // Sync request, active low pin with optional inversion and force modes
  wire pin_req = ~LINK_SYNC_REQUEST_PIN_N_I ^ coding_reg[`JTXL_SYNC_INV];
  wire sync_req = (sync_ctrl == `JTXL_SYNC_FORCE_CGS) ? 1'b1 :
                  (sync_ctrl == `JTXL_SYNC_FORCE_DATA) ? 1'b0 : pin_req;

  // Register read select
  wire [7:0] status = {2'b00, user_done_reg, sync_req, 2'b00, state_reg};
  wire [7:0] rd_mux = hit_coding ? coding_reg :
                      hit_ctrl3 ? ctrl3_reg :
                      hit_ctrl4 ? ctrl4_reg :
                      (idx == `JTXL_IDX_CSUM) ? csum_reg :
                      (idx == `JTXL_IDX_STATUS) ? status :
                      hit_user ? user_reg : 8'h00;

  // Checksum select
  wire [7:0] csum_next = (csum_mode == JTXL_CS_BYTES) ? byte_sum(CFG_TABLE_I) :
                         (csum_mode == JTXL_CS_FIELDS) ? field_sum(CFG_TABLE_I) :
                         8'h00;

  // Pattern generation
  wire [40:0] prbs_nx = prbs_step(prbs_reg, tpat);
  wire is_pn = (tpat >= JTXL_TP_PN31) && (tpat <= JTXL_TP_PN7);
  wire tpat_known = (tpat <= JTXL_TP_RAMP) || (tpat >= JTXL_TP_USER_REP);
  wire pat_on = (tpat != JTXL_TP_OFF) && tpat_known &&
                !((tpat == JTXL_TP_USER_ONE) && user_done_reg);
  wire [9:0] pat = (tpat == JTXL_TP_CHECKER) ?
                   (phase_reg ? `JTXL_CHECKER_B : `JTXL_CHECKER_A) :
                   (tpat == JTXL_TP_TOGGLE) ? {10{phase_reg}} :
                   is_pn ? prbs_nx[40:31] :
                   (tpat == JTXL_TP_RAMP) ? ramp_reg :
                   {2'b00, user_reg};
  wire inj_sample = pat_on && (inj == JTXL_INJ_SAMPLE);
  wire inj_symbol = pat_on && (inj == JTXL_INJ_SYMBOL);
  wire inj_scr = pat_on && (inj == JTXL_INJ_SCRAMBLER);

  // Octet path and symbol path
  wire [7:0] octet_src = inj_sample ? pat[7:0] : SAMPLE_I;
  wire in_cgs = state_reg == JTXL_ST_CGS;
  wire [7:0] link_oct = in_cgs ? `JTXL_K28_5 : octet_src;
  wire [7:0] scr_next = inj_scr ? pat[7:0] : link_oct;
  wire scr_k_next = in_cgs & ~inj_scr;
  wire [9:0] sym_raw = bypass ? {2'b00, SCRAMBLED_I} : ENC_SYMBOL_I;
  wire [9:0] sym_sel = inj_symbol ? pat : sym_raw;
  wire [9:0] line_next = invert ? ~sym_sel : sym_sel;

  // Alignment start
  wire lmfc_hit = LMFC_I && (lmfc_cnt_reg == ilas_dly);
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      JTXL_ST_CGS: if (!sync_req) state_next = JTXL_ST_WAIT;
      JTXL_ST_WAIT: begin
        if (sync_req) state_next = JTXL_ST_CGS;
        else if (lmfc_hit) state_next = JTXL_ST_DATA;
      end
      JTXL_ST_DATA: if (sync_req) state_next = JTXL_ST_CGS;
      default: state_next = JTXL_ST_CGS;
    endcase
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else begin
      ack_reg <= wb_req & ~ack_reg;
      rdata_reg <= {24'h000000, rd_mux};
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      coding_reg <= `JTXL_RST_CODING;
      ctrl3_reg <= `JTXL_RST_CTRL3;
      ctrl4_reg <= `JTXL_RST_CTRL4;
      user_reg <= `JTXL_RST_USER;
    end else if (wr_en) begin
      if (hit_coding) coding_reg <= wbyte & `JTXL_WMASK_CODING;
      if (hit_ctrl3) ctrl3_reg <= wbyte & `JTXL_WMASK_CTRL3;
      if (hit_ctrl4) ctrl4_reg <= wbyte & `JTXL_WMASK_CTRL4;
      if (hit_user) user_reg <= wbyte & `JTXL_WMASK_USER;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (link_rst) begin
      state_reg <= JTXL_ST_CGS;
      lmfc_cnt_reg <= 4'h0;
      ilas_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ilas_reg <= (state_reg == JTXL_ST_WAIT) && (state_next == JTXL_ST_DATA);
      if (state_reg != JTXL_ST_WAIT) lmfc_cnt_reg <= 4'h0;
      else if (LMFC_I) lmfc_cnt_reg <= lmfc_cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (link_rst) begin
      prbs_reg <= `JTXL_PRBS_SEED;
      tpat_q_reg <= 4'h0;
      phase_reg <= 1'b0;
      ramp_reg <= 10'h000;
      user_done_reg <= 1'b0;
    end else begin
      tpat_q_reg <= tpat;
      phase_reg <= (tpat == tpat_q_reg) ? ~phase_reg : 1'b0;
      prbs_reg <= (tpat == tpat_q_reg) ? prbs_nx[30:0] : `JTXL_PRBS_SEED;
      ramp_reg <= (tpat == tpat_q_reg) ? ramp_reg + 10'h001 : 10'h000;
      user_done_reg <= (tpat == JTXL_TP_USER_ONE);
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (link_rst) begin
      scr_data_reg <= 8'h00;
      scr_k_reg <= 1'b0;
      line_reg <= 10'h000;
      csum_reg <= 8'h00;
    end else begin
      scr_data_reg <= scr_next;
      scr_k_reg <= scr_k_next;
      line_reg <= line_next;
      csum_reg <= csum_next;
    end
  end

  assign ACK_O = ack_reg;
  assign DAT_O = rdata_reg;
  assign SCR_DATA_O = scr_data_reg;
  assign SCR_K_O = scr_k_reg;
  assign LINE_SYMBOL_O = line_reg;
  assign ILAS_START_O = ilas_reg;
  assign CHECKSUM_O = csum_reg;
  assign LINK_STATE_O = state_reg;

  // Checks
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (link_rst);

  AST_BYPASS_ZERO: assert property (
    bypass && !invert && !inj_symbol |=> LINE_SYMBOL_O == {2'b00, $past(SCRAMBLED_I)})
    else $error("bypass symbol upper bits not zero");
  AST_INVERT: assert property (
    invert |=> LINE_SYMBOL_O == ~$past(sym_sel))
    else $error("symbol not inverted");
  AST_CSUM_BYTES: assert property (
    csum_mode == JTXL_CS_BYTES |=> CHECKSUM_O == byte_sum($past(CFG_TABLE_I)))
    else $error("byte checksum wrong");
  AST_CSUM_FIELDS: assert property (
    csum_mode == JTXL_CS_FIELDS |=> CHECKSUM_O == field_sum($past(CFG_TABLE_I)))
    else $error("field checksum wrong");
  AST_CSUM_ZERO: assert property (
    csum_mode == JTXL_CS_ZERO |=> CHECKSUM_O == 8'h00)
    else $error("test checksum not zero");
  AST_INJ_SYMBOL: assert property (
    inj_symbol && !invert |=> LINE_SYMBOL_O == $past(pat))
    else $error("symbol pattern not injected");
  AST_INJ_SCR: assert property (
    inj_scr |=> SCR_DATA_O == $past(pat[7:0]) && !SCR_K_O)
    else $error("scrambler pattern not injected");
  AST_NORMAL: assert property (
    tpat == JTXL_TP_OFF && state_reg == JTXL_ST_DATA |=> SCR_DATA_O == $past(SAMPLE_I))
    else $error("sample data not passed");
  AST_TOGGLE: assert property (
    tpat == JTXL_TP_TOGGLE && tpat_q_reg == tpat ##1 tpat == JTXL_TP_TOGGLE
    |-> pat == ~$past(pat))
    else $error("word toggle stuck");
  AST_PN7: assert property (
    tpat == JTXL_TP_PN7 && tpat_q_reg == tpat |=> prbs_reg[0] == (prbs_reg[7] ^ prbs_reg[6]))
    else $error("pn7 feedback wrong");
  AST_ILAS_DLY: assert property (
    ILAS_START_O |-> $past(LMFC_I) && $past(lmfc_cnt_reg) == $past(ilas_dly))
    else $error("alignment start on wrong boundary");
  AST_CGS: assert property (
    sync_req |=> ##1 SCR_K_O || $past(inj_scr))
    else $error("sync characters not sent");
  COV_ILAS: cover property (state_reg == JTXL_ST_WAIT ##[1:200] ILAS_START_O);
  COV_PN31: cover property (tpat == JTXL_TP_PN31 && inj_symbol [*4]);
  COV_USER_ONE: cover property (tpat == JTXL_TP_USER_ONE ##1 user_done_reg);
  COV_RESYNC: cover property (state_reg == JTXL_ST_DATA ##1 state_reg == JTXL_ST_CGS);
endmodule

// ==== logic/jtxl_params.svh ====
// Register indices, field positions, reset values and codes of the link control block
`ifndef JTXL_PARAMS_SVH
`define JTXL_PARAMS_SVH
`define JTXL_IDX_CODING 12'h572
`define JTXL_IDX_CTRL3 12'h573
`define JTXL_IDX_CTRL4 12'h574
`define JTXL_IDX_CSUM 12'h575
`define JTXL_IDX_STATUS 12'h576
`define JTXL_IDX_USER 12'h577
`define JTXL_RST_CODING 8'h00
`define JTXL_RST_CTRL3 8'h00
`define JTXL_RST_CTRL4 8'h00
`define JTXL_RST_USER 8'h00
`define JTXL_WMASK_CODING 8'hF7
`define JTXL_WMASK_CTRL3 8'hFF
`define JTXL_WMASK_CTRL4 8'hF7
`define JTXL_WMASK_USER 8'hFF
`define JTXL_SYNC_CTRL 7:6
`define JTXL_SYNC_INV 5
`define JTXL_BYPASS 2
`define JTXL_INVERT 1
`define JTXL_CSUM_MODE 7:6
`define JTXL_INJ_POINT 5:4
`define JTXL_TEST_PAT 3:0
`define JTXL_ILAS_DLY 7:4
`define JTXL_SYNC_FORCE_CGS 2'h2
`define JTXL_SYNC_FORCE_DATA 2'h3
`define JTXL_K28_5 8'hBC
`define JTXL_CHECKER_A 10'h2AA
`define JTXL_CHECKER_B 10'h155
`define JTXL_PRBS_SEED 31'h7FFFFFFF
`endif

// ==== logic/jtxl_pkg.sv ====
// Types shared by the link control block
package jtxl_pkg;
  typedef enum logic [1:0] {
    JTXL_ST_CGS = 2'b00,
    JTXL_ST_WAIT = 2'b01,
    JTXL_ST_DATA = 2'b10
  } jtxl_state_t;
  typedef enum logic [1:0] {
    JTXL_CS_BYTES = 2'b00,
    JTXL_CS_FIELDS = 2'b01,
    JTXL_CS_ZERO = 2'b10,
    JTXL_CS_UNUSED = 2'b11
  } jtxl_csum_t;
  typedef enum logic [1:0] {
    JTXL_INJ_SAMPLE = 2'b00,
    JTXL_INJ_SYMBOL = 2'b01,
    JTXL_INJ_SCRAMBLER = 2'b10,
    JTXL_INJ_NONE = 2'b11
  } jtxl_inj_t;
  typedef enum logic [3:0] {
    JTXL_TP_OFF = 4'h0,
    JTXL_TP_CHECKER = 4'h1,
    JTXL_TP_TOGGLE = 4'h2,
    JTXL_TP_PN31 = 4'h3,
    JTXL_TP_PN23 = 4'h4,
    JTXL_TP_PN15 = 4'h5,
    JTXL_TP_PN9 = 4'h6,
    JTXL_TP_PN7 = 4'h7,
    JTXL_TP_RAMP = 4'h8,
    JTXL_TP_USER_REP = 4'hE,
    JTXL_TP_USER_ONE = 4'hF
  } jtxl_tpat_t;
endpackage
